/* File: ccic_pkg.sv */
package ccic_pkg;
    // -----------------------------------------------
    // Register indices and byte addresses
    // -----------------------------------------------
    localparam logic [12:0] IDX_RATE = 13'h180A;
    localparam logic [12:0] IDX_EN = 13'h180B;
    localparam logic [12:0] IDX_FLAG = 13'h180C;
    localparam logic [14:0] ADDR_RATE = {IDX_RATE, 2'b00};
    localparam logic [14:0] ADDR_EN = {IDX_EN, 2'b00};
    localparam logic [14:0] ADDR_FLAG = {IDX_FLAG, 2'b00};
    localparam int ADDR_W = 15;

    // -----------------------------------------------
    // Field positions
    // -----------------------------------------------
    localparam int UNDERWAY_BIT = 7;
    localparam int RATE_W = 5;
    localparam int ISOLATE_BIT = 7;
    localparam int HOUR_FMT_BIT = 1;
    localparam int ANY_REQ_BIT = 7;
    localparam int EV_LSB = 4;
    localparam int EV_W = 3;
    localparam int EV_UPD = 0;
    localparam int EV_ALM = 1;
    localparam int EV_PER = 2;

    // -----------------------------------------------
    // Rate codes and reset values
    // -----------------------------------------------
    localparam logic [4:0] RATE_OFF = 5'h00;
    localparam logic [4:0] RATE_FIRST = 5'h03;
    localparam logic [4:0] RATE_LAST = 5'h0F;
    localparam logic [4:0] RATE_MINUTE = 5'h10;
    localparam logic [4:0] RATE_RST = 5'h00;
    localparam int TICK_W = 15;

    // -----------------------------------------------
    // Timing
    // -----------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int UPD_LEAD_US = 244;
    localparam int UPD_LEAD_CYC = UPD_LEAD_US * CLK_MHZ;
endpackage

/* File: ccic_irq_ctrl.sv */
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - Rate register bit 7 shows update underway
// - Unused bits read zero, ignore writes
// - Rate code zero gives no periodic events
// - Codes 3..15 halve rate from 8192/s
// - Codes 16..31 give one event per minute
// - Isolate bit disconnects buffers from counters
// - Isolate bit survives host reset
// - Periodic enable gates periodic flag onto request
// - Alarm enable gates alarm flag onto request
// - Update enable gates update flag onto request
// - Hour format bit, survives host reset
// - Summary bit set when flag and enable
// - Writing one clears the addressed flag
// - Periodic flag sets only while enabled
// - Alarm flag sets only while enabled
// - Update flag sets only while enabled
// - Counter update within 244 us of rise
// - Completed update raises update-done event
module ccic_irq_ctrl
    import ccic_pkg::*;
#(
    parameter int LEAD_CYC = UPD_LEAD_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n, // Power-on reset, clears only the kept bits
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tick_32k, // One pulse per 32.768 kHz period
    input wire logic second_tick, // Starts an update cycle
    input wire logic minute_tick, // Minute rollover from counters
    input wire logic alarm_match, // Alarm comparison hit
    output logic counter_update, // One-cycle advance of counters
    output logic update_underway,
    output logic buffers_isolated,
    output logic hour_format_select,
    output logic irq
);

    // -----------------------------------------------
    // Types and storage
    // -----------------------------------------------
    typedef enum logic [1:0] {UPD_IDLE, UPD_LEAD, UPD_DONE} ccic_upd_t;

    ccic_upd_t upd_q, upd_d;
    logic [31:0] lead_q, lead_d; // Lead-time counter
    logic [RATE_W-1:0] rate_q; // Periodic rate select
    logic [EV_W-1:0] en_q; // Per-source enables
    logic [EV_W-1:0] flag_q; // Sticky event flags
    logic isolate_q; // Buffer isolate control
    logic fmt_q; // Hour format
    logic [TICK_W-1:0] tick_q; // Free-running 32k divider
    logic underway_q;
    logic cupd_q;
    logic irq_q;
    logic [31:0] rdata_q;
    logic ready_q;
    logic err_q;

    // -----------------------------------------------
    // Bus decode
    // -----------------------------------------------
    // Mask of divider bits that must be all-ones for an event
    function automatic logic [TICK_W-1:0] rate_mask(input logic [RATE_W-1:0] r);
        logic [TICK_W-1:0] m;
        m = '0;
        for (int i = 0; i < TICK_W; i++) begin
            if (i < 32'(r) - 1) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Address match on the low 15 bits, with all higher address bits zero
    function automatic logic hit(input logic [31:0] a, input logic [ADDR_W-1:0] r);
        return (a[ADDR_W-1:0] == r) && (a[31:ADDR_W] == '0);
    endfunction

    wire setup = psel && !penable;
    wire access = psel && penable && ready_q;
    wire hit_rate = hit(paddr, ADDR_RATE);
    wire hit_en = hit(paddr, ADDR_EN);
    wire hit_flag = hit(paddr, ADDR_FLAG);
    wire mapped = hit_rate || hit_en || hit_flag;
    wire wr_en = access && pwrite && hit_en;
    wire wr_rate = access && pwrite && hit_rate;
    wire wr_flag = access && pwrite && hit_flag;
    wire [EV_W-1:0] w1c = wr_flag ? pwdata[EV_LSB +: EV_W] : '0;
    // Enables after this edge, so the request flop sees an enable write at once
    wire [EV_W-1:0] en_next = wr_en ? pwdata[EV_LSB +: EV_W] : en_q;

    // Read views; unused bits are tied low
    wire [7:0] view_rate = {underway_q, 2'b00, rate_q};
    wire [7:0] view_en = {isolate_q, en_q, 2'b00, fmt_q, 1'b0};
    wire pending = |(flag_q & en_q);
    wire [7:0] view_flag = {pending, flag_q, 4'h0};
    wire [7:0] view = hit_rate ? view_rate : hit_en ? view_en : hit_flag ? view_flag : 8'h00;

    // -----------------------------------------------
    // Event sources
    // -----------------------------------------------
    wire [TICK_W-1:0] mask = rate_mask(rate_q);
    wire rate_fast = (rate_q >= RATE_FIRST) && (rate_q <= RATE_LAST);
    wire rate_min = (rate_q >= RATE_MINUTE);
    // Code zero and the two reserved codes fall through to no event
    wire per_evt = (rate_fast && tick_32k && ((tick_q & mask) == mask))
        || (rate_min && minute_tick);
    // Taken from the next state so the flag rises with the counter advance pulse
    wire upd_evt = (upd_d == UPD_DONE);
    wire [EV_W-1:0] raw_evt = {per_evt, alarm_match, upd_evt};
    wire [EV_W-1:0] set_evt = raw_evt & en_q;
    // A new event wins over a same-cycle clear
    wire [EV_W-1:0] flag_next = (flag_q & ~w1c) | set_evt;

    // -----------------------------------------------
    // APB answer: one wait-free access cycle
    // -----------------------------------------------
    // Read data is captured in setup so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ready_q <= setup;
            err_q <= setup && !mapped;
            if (setup && !pwrite) begin
                rdata_q <= {24'h000000, view};
            end
        end
    end

    // -----------------------------------------------
    // Host-reset control: enables, flags
    // -----------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= '0;
            flag_q <= '0;
        end else begin
            if (wr_en) begin
                en_q <= pwdata[EV_LSB +: EV_W];
            end
            flag_q <= flag_next;
        end
    end

    // -----------------------------------------------
    // Kept bits: only power-on reset clears them
    // -----------------------------------------------
    // The rate field is kept too: a host reset must not change the tick rate
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            rate_q <= RATE_RST;
            isolate_q <= 1'b0;
            fmt_q <= 1'b0;
        end else begin
            if (wr_rate) begin
                rate_q <= pwdata[RATE_W-1:0];
            end
            if (wr_en) begin
                isolate_q <= pwdata[ISOLATE_BIT];
                fmt_q <= pwdata[HOUR_FMT_BIT];
            end
        end
    end

    // -----------------------------------------------
    // Periodic divider
    // -----------------------------------------------
    // Free-running so the rate can change without a restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= '0;
        end else if (tick_32k) begin
            tick_q <= tick_q + 1'b1;
        end
    end

    // -----------------------------------------------
    // Update cycle sequencer
    // -----------------------------------------------
    always_comb begin
        upd_d = upd_q;
        lead_d = lead_q;
        case (upd_q)
            UPD_IDLE: begin
                lead_d = '0;
                if (second_tick) begin
                    upd_d = UPD_LEAD;
                end
            end
            UPD_LEAD: begin
                // Advance counters before the lead time runs out
                lead_d = lead_q + 1;
                if (lead_q >= 32'(LEAD_CYC) - 2) begin
                    upd_d = UPD_DONE;
                end
            end
            UPD_DONE: begin
                upd_d = UPD_IDLE;
            end
            default: begin
                upd_d = UPD_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_q <= UPD_IDLE;
            lead_q <= '0;
            underway_q <= 1'b0;
            cupd_q <= 1'b0;
        end else begin
            upd_q <= upd_d;
            lead_q <= lead_d;
            underway_q <= (upd_d == UPD_LEAD) || (upd_d == UPD_DONE);
            cupd_q <= (upd_d == UPD_DONE);
        end
    end

    // -----------------------------------------------
    // Interrupt request
    // -----------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            // Next flags and enables, so irq always equals the summary bit
            irq_q <= |(flag_next & en_next);
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign counter_update = cupd_q;
    assign update_underway = underway_q;
    assign buffers_isolated = isolate_q;
    assign hour_format_select = fmt_q;
    assign irq = irq_q;

    // -----------------------------------------------
    // Assertions
    // -----------------------------------------------
    logic [31:0] uw_cnt_q; // Cycles the underway level has stood
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uw_cnt_q <= '0;
        end else begin
            uw_cnt_q <= underway_q ? uw_cnt_q + 1 : '0;
        end
    end

    property p_underway_bound;
        @(posedge pclk) disable iff (!presetn) uw_cnt_q <= 32'(LEAD_CYC);
    endproperty
    a_underway_bound: assert property (p_underway_bound) else $error("update lead too long");

    property p_irq_follows;
        @(posedge pclk) disable iff (!presetn) irq_q == pending;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq not matching flags");

    property p_per_gated;
        @(posedge pclk) disable iff (!presetn) $rose(flag_q[EV_PER]) |-> $past(en_q[EV_PER]);
    endproperty
    a_per_gated: assert property (p_per_gated) else $error("periodic flag set while disabled");

    property p_alm_gated;
        @(posedge pclk) disable iff (!presetn) $rose(flag_q[EV_ALM]) |-> $past(en_q[EV_ALM]);
    endproperty
    a_alm_gated: assert property (p_alm_gated) else $error("alarm flag set while disabled");

    property p_upd_flag;
        @(posedge pclk) disable iff (!presetn) cupd_q && en_q[EV_UPD] |-> flag_q[EV_UPD];
    endproperty
    a_upd_flag: assert property (p_upd_flag) else $error("update flag missing");

    property p_flag_fall;
        @(posedge pclk) disable iff (!presetn)
            $fell(flag_q[EV_UPD]) |-> $past(wr_flag && pwdata[EV_LSB + EV_UPD]);
    endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("flag cleared without w1c");

    property p_w1c;
        @(posedge pclk) disable iff (!presetn)
            wr_flag && pwdata[EV_LSB + EV_ALM] && !alarm_match |=> !flag_q[EV_ALM];
    endproperty
    a_w1c: assert property (p_w1c) else $error("w1c did not clear");

    property p_rate_off;
        @(posedge pclk) disable iff (!presetn) (rate_q < RATE_FIRST) |-> !per_evt;
    endproperty
    a_rate_off: assert property (p_rate_off) else $error("event at off rate");

    property p_read_uip;
        @(posedge pclk) disable iff (!presetn)
            setup && !pwrite && hit_rate |=> prdata[UNDERWAY_BIT] == $past(underway_q) && prdata[6:5] == 2'b00;
    endproperty
    a_read_uip: assert property (p_read_uip) else $error("bad rate register read");

    property p_upd_gated;
        @(posedge pclk) disable iff (!presetn) $rose(flag_q[EV_UPD]) |-> $past(en_q[EV_UPD]);
    endproperty
    a_upd_gated: assert property (p_upd_gated) else $error("update flag set while disabled");

    property p_upd_with_pulse;
        @(posedge pclk) disable iff (!presetn) $rose(flag_q[EV_UPD]) |-> cupd_q;
    endproperty
    a_upd_with_pulse: assert property (p_upd_with_pulse) else $error("update flag without update");

    property p_underway_fall;
        @(posedge pclk) disable iff (!presetn) $fell(underway_q) |-> $past(cupd_q);
    endproperty
    a_underway_fall: assert property (p_underway_fall) else $error("underway fell before update");

    property p_read_flags;
        @(posedge pclk) disable iff (!presetn)
            setup && !pwrite && hit_flag |=> prdata[ANY_REQ_BIT] == $past(pending) && prdata[EV_LSB-1:0] == '0;
    endproperty
    a_read_flags: assert property (p_read_flags) else $error("bad flag register read");

    property p_zero_write;
        @(posedge pclk) disable iff (!presetn)
            wr_flag && (w1c == '0) |=> flag_q == ($past(flag_q) | $past(set_evt));
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write changed flags");

    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq_q));
    c_update: cover property (@(posedge pclk) disable iff (!presetn) $fell(underway_q));
    c_per: cover property (@(posedge pclk) disable iff (!presetn) per_evt && en_q[EV_PER]);
    c_clear: cover property (@(posedge pclk) disable iff (!presetn) wr_flag && (w1c != '0));
endmodule

/* File: ccic_cnt_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Counter-side stand-in: crystal ticks and events
// ---------------------------------------------
module ccic_cnt_model #(
    parameter int TDIV = 4 // Clock cycles per 32 kHz tick, shortened
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sec_req, // Bench asks for an update cycle
    input wire logic min_req, // Bench asks for a minute rollover
    input wire logic alm_req, // Bench asks for an alarm hit
    input wire logic counter_update,
    output logic tick_32k,
    output logic second_tick,
    output logic minute_tick,
    output logic alarm_match,
    output int upd_count // Counter advances seen
);
    int div_q = 0; // Free divider, never stopped
    // The crystal keeps running through a host reset
    always_ff @(posedge pclk) begin
        div_q <= (div_q == TDIV - 1) ? 0 : div_q + 1;
        tick_32k <= (div_q == TDIV - 1);
    end
    // Events are one-cycle pulses launched off the edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_tick <= 1'b0;
            minute_tick <= 1'b0;
            alarm_match <= 1'b0;
            upd_count <= 0;
        end else begin
            second_tick <= sec_req;
            minute_tick <= min_req;
            alarm_match <= alm_req;
            if (counter_update) begin
                upd_count <= upd_count + 1;
            end
        end
    end
endmodule

/* File: test_clock_calendar_irq_control.sv */
`timescale 1ns/1ps
module test_clock_calendar_irq_control;
    import ccic_pkg::*;
    localparam int LEAD = 20; // Short update lead so runs stay brief
    localparam int TDIV = 4;
    logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic tick_32k, second_tick, minute_tick, alarm_match, counter_update;
    logic update_underway, buffers_isolated, hour_format_select, irq;
    logic sec_req, min_req, alm_req;
    int err_count = 0, check_count = 0, cyc = 0, upd_count, t1, t2;
    ccic_irq_ctrl #(.LEAD_CYC(LEAD)) DUT (.pclk(pclk), .presetn(presetn), .por_n(por_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tick_32k(tick_32k),
        .second_tick(second_tick), .minute_tick(minute_tick), .alarm_match(alarm_match),
        .counter_update(counter_update), .update_underway(update_underway),
        .buffers_isolated(buffers_isolated), .hour_format_select(hour_format_select), .irq(irq));
    ccic_cnt_model #(.TDIV(TDIV)) far (.pclk(pclk), .presetn(presetn), .sec_req(sec_req),
        .min_req(min_req), .alm_req(alm_req), .counter_update(counter_update),
        .tick_32k(tick_32k), .second_tick(second_tick), .minute_tick(minute_tick),
        .alarm_match(alarm_match), .upd_count(upd_count));
    // ---------------------------------------------
    // Clock, cycle count and watchdog
    // ---------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always_ff @(posedge pclk) cyc <= cyc + 1;
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        test_done();
    end
    // ---------------------------------------------
    // Shared tasks
    // ---------------------------------------------
    task automatic test_done();
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; holds the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [14:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {17'h00000, a};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) check(32'h0, 32'h1);
        // Idle edge keeps psel from being driven twice in one step
        @(posedge pclk);
    endtask
    task automatic rchk(input logic [14:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        check(rd, {24'h000000, exp});
    endtask
    // k: 0 update start, 1 minute rollover, 2 alarm hit
    task automatic ev(input int k);
        sec_req <= (k == 0);
        min_req <= (k == 1);
        alm_req <= (k == 2);
        @(posedge pclk);
        sec_req <= 1'b0;
        min_req <= 1'b0;
        alm_req <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        t = cyc;
        if (n >= 3000) check(32'h0, 32'h1);
    endtask
    task automatic upd(input logic [7:0] fexp);
        int t0;
        t0 = cyc;
        ev(0);
        rchk(ADDR_RATE, 8'h80);
        while (counter_update !== 1'b1 && cyc - t0 < LEAD + 10) @(posedge pclk);
        check({31'h0, counter_update}, 32'h1);
        check({31'h0, (cyc - t0) <= LEAD + 2}, 32'h1);
        repeat (3) @(posedge pclk);
        check({31'h0, update_underway}, 32'h0);
        rchk(ADDR_FLAG, fexp);
    endtask
    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        {presetn, por_n, psel, penable, pwrite, sec_req, min_req, alm_req} = 8'h00;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge pclk);
        rchk(ADDR_RATE, 8'h00);
        rchk(ADDR_EN, 8'h00);
        rchk(ADDR_FLAG, 8'h00);
        apb(1'b0, 15'h6034, 8'h00);
        check({31'h0, err}, 32'h1);
        apb(1'b1, ADDR_RATE, 8'hFF);
        rchk(ADDR_RATE, 8'h1F);
        apb(1'b1, ADDR_EN, 8'hFF);
        rchk(ADDR_EN, 8'hF2);
        check({30'h0, buffers_isolated, hour_format_select}, 32'h3);
        // Host reset keeps isolate, hour format and the rate field
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(ADDR_EN, 8'h82);
        rchk(ADDR_RATE, 8'h1F);
        apb(1'b1, ADDR_EN, 8'h00);
        check({30'h0, buffers_isolated, hour_format_select}, 32'h0);
        // Alarm flag: gated, masked, zero writes, cleared
        ev(2);
        rchk(ADDR_FLAG, 8'h00);
        apb(1'b1, ADDR_EN, 8'h20);
        ev(2);
        rchk(ADDR_FLAG, 8'hA0);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_EN, 8'h00);
        rchk(ADDR_FLAG, 8'h20);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_EN, 8'h20);
        apb(1'b1, ADDR_FLAG, 8'h00);
        apb(1'b1, ADDR_FLAG, 8'h8F);
        rchk(ADDR_FLAG, 8'hA0);
        apb(1'b1, ADDR_FLAG, 8'h20);
        rchk(ADDR_FLAG, 8'h00);
        check({31'h0, irq}, 32'h0);
        // Update cycles, first with the update enable off
        apb(1'b1, ADDR_RATE, 8'h00);
        upd(8'h00);
        apb(1'b1, ADDR_EN, 8'h10);
        upd(8'h90);
        check(upd_count, 32'h2);
        // Periodic: code zero silent, enable gates the flag
        apb(1'b1, ADDR_EN, 8'h40);
        apb(1'b1, ADDR_FLAG, 8'h70);
        repeat (200) @(posedge pclk);
        rchk(ADDR_FLAG, 8'h00);
        apb(1'b1, ADDR_EN, 8'h00);
        apb(1'b1, ADDR_RATE, 8'h03);
        repeat (100) @(posedge pclk);
        rchk(ADDR_FLAG, 8'h00);
        apb(1'b1, ADDR_EN, 8'h40);
        // Longer codes are left out: their periods would swamp the run
        for (int c = 3; c < 8; c++) begin
            apb(1'b1, ADDR_RATE, c[7:0]);
            apb(1'b1, ADDR_FLAG, 8'h70);
            wait_irq(t1);
            apb(1'b1, ADDR_FLAG, 8'h40);
            wait_irq(t2);
            check(t2 - t1, (1 << (c - 1)) * TDIV);
        end
        // Minute codes, lowest and highest
        for (int c = 16; c < 32; c += 15) begin
            apb(1'b1, ADDR_RATE, c[7:0]);
            apb(1'b1, ADDR_FLAG, 8'h70);
            rchk(ADDR_FLAG, 8'h00);
            ev(1);
            rchk(ADDR_FLAG, 8'hC0);
        end
        test_done();
    end
endmodule
